// ---- hdl/epiu_defs.svh ----
/*
   Register indices, field positions, reset values and encodings of the
   external pin interrupt unit.
   Assumes it is included by bare name wherever these constants are used.
*/
`ifndef EPIU_DEFS_SVH
`define EPIU_DEFS_SVH

// ============================================================
// Register indices; the byte address is four times the index.
`define EPIU_IDX_ENABLE_MASK 10'h01D
`define EPIU_IDX_GROUP_ENABLE 10'h068
`define EPIU_IDX_MASK_HIGH 10'h06D
`define EPIU_IDX_MASK_MID 10'h06C
`define EPIU_IDX_MASK_LOW 10'h06B
`define EPIU_IDX_SENSE 10'h070
`define EPIU_IDX_EXT_FLAGS 10'h071
`define EPIU_IDX_GROUP_FLAGS 10'h072

// ============================================================
// Field layout and reset values.
`define EPIU_RESET_BYTE 8'h00
`define EPIU_RESET_PAIR 2'h0
`define EPIU_RESET_TRIO 3'h0
`define EPIU_PIN_IDLE 26'h3FFFFFF
`define EPIU_MASK_MID_BITS 8'h7F
`define EPIU_IRQ_BASE 24
`define EPIU_GROUP_WIDTH 8
`define EPIU_SENSE_WIDTH 2
`define EPIU_PAD_FILL_32_8 24'h000000
`define EPIU_PAD_FILL_32_4 28'h0000000
`define EPIU_PAD_FILL_32_3 29'h0000000
`define EPIU_PAD_FILL_32_2 30'h0000000
`define EPIU_READ_ZERO 32'h00000000

// ============================================================
// Sense encodings and bus codes.
`define EPIU_SENSE_LOW 2'h0
`define EPIU_SENSE_ANY 2'h1
`define EPIU_SENSE_FALL 2'h2
`define EPIU_SENSE_RISE 2'h3
`define EPIU_HSIZE_WORD 3'h2
`define EPIU_HRESP_OKAY 1'h0

`endif

// ---- hdl/epiu_pkg.sv ----
/*
   Types shared by the external pin interrupt unit.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package epiu_pkg;

   // Pad levels: irq[1] is the second dedicated pin, irq[0] the first.
   typedef struct packed {
      logic [1:0] irq;
      logic [23:0] change;
   } epiu_pins_type;

   // Requests or handler entries: pin[1] second, pin[0] first; group[2] high.
   typedef struct packed {
      logic [1:0] pin;
      logic [2:0] group;
   } epiu_req_type;

   typedef enum logic [1:0] {
      phase_idle,
      phase_write,
      phase_read_wait,
      phase_read_out
   } epiu_phase_type;

endpackage

// ---- hdl/epiu_top.sv ----
/*
   External pin interrupt unit: two dedicated sense-selectable pins, three
   pin-change groups, their flags and masks, and an AHB-Lite register slave.
   Assumes the core drives the global interrupt bit and pulses one handler
   entry bit for each handler it enters; pads arrive asynchronously.
*/
`timescale 1ns/1ns
`include "epiu_defs.svh"

// Function
// - Pins acting as outputs still raise interrupts
// - Three change groups: 23..16, 14..8, 7..0
// - Per-pin masks select group contributors
// - Pin changes detected without running clock
// - Enabled low level requests while pin low
// - Edges recognised only while clock runs
// - Low level detected without a clock
// - Level must outlast start-up to interrupt
// - Second pin sense: low, change, fall, rise
// - First pin sense: low, change, fall, rise
// - Pins sampled; pulses over two periods caught
// - Per-pin enable gated by global bit
// - Unused register bits read as zero
// - Second pin flag set on trigger, vectors
// - Handler entry clears the pin flag
// - Writing one clears flag, zero ignored
// - Flag held clear in level mode
// - First pin flag behaves like second
// - Group enable bits at index 0x68
// - Group flags set on change, cleared likewise
// - Pin mask registers at 0x6D, 0x6C, 0x6B
module epiu_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire epiu_pkg::epiu_pins_type pad_in,
   input wire logic global_irq_enable,
   input wire epiu_pkg::epiu_req_type handler_entry,
   output epiu_pkg::epiu_req_type irq_request,
   output logic wake_request
);

   // ============================================================
   // Declarations.
   epiu_pkg::epiu_phase_type phase;
   epiu_pkg::epiu_phase_type next_phase;
   logic [9:0] dp_index;
   logic [25:0] pad_vec;
   logic [25:0] sync1;
   logic [25:0] sync2;
   logic [25:0] sync3;
   logic [25:0] stable;
   logic [25:0] pin_change;
   logic [7:0] sense_control;
   logic [1:0] enable_mask;
   logic [1:0] pin_flag;
   logic [2:0] group_enable;
   logic [2:0] group_flag;
   logic [2:0][7:0] pin_mask;
   logic [23:0] mask_vec;
   logic [23:0] group_en_vec;
   logic [1:0] pin_trigger;
   logic [1:0] pin_level_mode;
   logic [1:0] pin_level_req;
   logic [2:0] group_trigger;
   logic wr_strobe;
   logic [31:0] read_value;
   logic addr_take;

   assign pad_vec = pad_in;

   // ============================================================
   // Pad resynchronisation and change detection.
   // The pads are read directly, so a pin driven by its own port output still
   // counts exactly like an external source.
   genvar b;
   generate
      for (b = 0; b < 26; b++)
      begin : g_sync
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               sync1[b] <= 1'b1;
               sync2[b] <= 1'b1;
               sync3[b] <= 1'b1;
               stable[b] <= 1'b1;
            end
            else
            begin
               sync1[b] <= pad_vec[b];
               sync2[b] <= sync1[b];
               sync3[b] <= sync2[b];
               if (sync2[b] == sync3[b])
               begin
                  stable[b] <= sync3[b];
               end
            end
         end
         // A change counts once two sampled stages agree on a new level.
         assign pin_change[b] = (sync2[b] == sync3[b]) && (sync3[b] != stable[b]);
      end
   endgenerate

   // ============================================================
   // Dedicated pins: sense decode, flags and requests.
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_pin
         logic [1:0] sense;
         assign sense = sense_control[`EPIU_SENSE_WIDTH*p +: `EPIU_SENSE_WIDTH];

         // Edges only come from the clocked samplers.
         always_comb
         begin
            pin_trigger[p] = 1'b0;
            case (sense)
               `EPIU_SENSE_LOW: pin_trigger[p] = 1'b0;
               `EPIU_SENSE_ANY: pin_trigger[p] = pin_change[`EPIU_IRQ_BASE+p];
               `EPIU_SENSE_FALL: pin_trigger[p] = pin_change[`EPIU_IRQ_BASE+p]
                  && !sync3[`EPIU_IRQ_BASE+p];
               `EPIU_SENSE_RISE: pin_trigger[p] = pin_change[`EPIU_IRQ_BASE+p]
                  && sync3[`EPIU_IRQ_BASE+p];
               default: pin_trigger[p] = 1'b0;
            endcase
         end

         assign pin_level_mode[p] = (sense == `EPIU_SENSE_LOW);
         // The level request follows the synchronised pin, so a level that
         // is gone before the clock returns raises no request.
         assign pin_level_req[p] = pin_level_mode[p] && !stable[`EPIU_IRQ_BASE+p];

         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               pin_flag[p] <= 1'b0;
            end
            else if (pin_level_mode[p])
            begin
               pin_flag[p] <= 1'b0;
            end
            else if (pin_trigger[p])
            begin
               pin_flag[p] <= 1'b1;
            end
            else if (handler_entry.pin[p])
            begin
               pin_flag[p] <= 1'b0;
            end
            else if (wr_strobe && dp_index == `EPIU_IDX_EXT_FLAGS && hwdata[p])
            begin
               pin_flag[p] <= 1'b0;
            end
         end

         assign irq_request.pin[p] = global_irq_enable && enable_mask[p]
            && (pin_level_mode[p] ? pin_level_req[p] : pin_flag[p]);
      end
   endgenerate

   // ============================================================
   // Pin-change groups: flags and requests.
   assign mask_vec = {pin_mask[2], pin_mask[1] & `EPIU_MASK_MID_BITS, pin_mask[0]};

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_group
         assign group_en_vec[`EPIU_GROUP_WIDTH*g +: `EPIU_GROUP_WIDTH] =
            {`EPIU_GROUP_WIDTH{group_enable[g]}};
         assign group_trigger[g] =
            |(pin_change[`EPIU_GROUP_WIDTH*g +: `EPIU_GROUP_WIDTH]
            & mask_vec[`EPIU_GROUP_WIDTH*g +: `EPIU_GROUP_WIDTH]);

         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               group_flag[g] <= 1'b0;
            end
            else if (group_trigger[g])
            begin
               group_flag[g] <= 1'b1;
            end
            else if (handler_entry.group[g])
            begin
               group_flag[g] <= 1'b0;
            end
            else if (wr_strobe && dp_index == `EPIU_IDX_GROUP_FLAGS && hwdata[g])
            begin
               group_flag[g] <= 1'b0;
            end
         end

         assign irq_request.group[g] = global_irq_enable && group_enable[g]
            && group_flag[g];
      end
   endgenerate

   // ============================================================
   // Clockless wake: raw change pads compared with the last settled levels; raw dedicated pads in level mode tested for low.
   always_comb
   begin
      wake_request = |((pad_in.change ^ stable[23:0]) & mask_vec & group_en_vec);
      wake_request = wake_request
         || (|(~pad_in.irq & enable_mask & pin_level_mode));
   end

   // ============================================================
   // AHB-Lite slave: writes complete with no wait, reads take one wait.
   assign addr_take = hsel && hready && htrans[1] && (hsize == `EPIU_HSIZE_WORD);
   assign wr_strobe = (phase == epiu_pkg::phase_write);
   assign hreadyout = (phase != epiu_pkg::phase_read_wait);
   assign hresp = `EPIU_HRESP_OKAY;

   always_comb
   begin
      next_phase = epiu_pkg::phase_idle;
      case (phase)
         epiu_pkg::phase_read_wait: next_phase = epiu_pkg::phase_read_out;
         epiu_pkg::phase_idle,
         epiu_pkg::phase_write,
         epiu_pkg::phase_read_out:
         begin
            if (addr_take)
            begin
               next_phase = hwrite ? epiu_pkg::phase_write : epiu_pkg::phase_read_wait;
            end
         end
         default: next_phase = epiu_pkg::phase_idle;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         phase <= epiu_pkg::phase_idle;
         dp_index <= 10'h000;
      end
      else
      begin
         phase <= next_phase;
         if (addr_take && phase != epiu_pkg::phase_read_wait)
         begin
            dp_index <= haddr[11:2];
         end
      end
   end

   // Read multiplexer; unmapped indices and unused bits read as zero.
   always_comb
   begin
      read_value = `EPIU_READ_ZERO;
      case (dp_index)
         `EPIU_IDX_ENABLE_MASK: read_value = {`EPIU_PAD_FILL_32_2, enable_mask};
         `EPIU_IDX_SENSE: read_value = {`EPIU_PAD_FILL_32_4, sense_control[3:0]};
         `EPIU_IDX_EXT_FLAGS: read_value = {`EPIU_PAD_FILL_32_2, pin_flag};
         `EPIU_IDX_GROUP_ENABLE: read_value = {`EPIU_PAD_FILL_32_3, group_enable};
         `EPIU_IDX_GROUP_FLAGS: read_value = {`EPIU_PAD_FILL_32_3, group_flag};
         `EPIU_IDX_MASK_HIGH: read_value = {`EPIU_PAD_FILL_32_8, pin_mask[2]};
         `EPIU_IDX_MASK_MID: read_value = {`EPIU_PAD_FILL_32_8,
            pin_mask[1] & `EPIU_MASK_MID_BITS};
         `EPIU_IDX_MASK_LOW: read_value = {`EPIU_PAD_FILL_32_8, pin_mask[0]};
         default: read_value = `EPIU_READ_ZERO;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= `EPIU_READ_ZERO;
      end
      else if (phase == epiu_pkg::phase_read_wait)
      begin
         hrdata <= read_value;
      end
   end

   // ============================================================
   // Control registers.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         enable_mask <= `EPIU_RESET_PAIR;
         sense_control <= `EPIU_RESET_BYTE;
      end
      else if (wr_strobe)
      begin
         if (dp_index == `EPIU_IDX_ENABLE_MASK)
         begin
            enable_mask <= hwdata[1:0];
         end
         if (dp_index == `EPIU_IDX_SENSE)
         begin
            sense_control <= {4'h0, hwdata[3:0]};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         group_enable <= `EPIU_RESET_TRIO;
         pin_mask <= {3{`EPIU_RESET_BYTE}};
      end
      else if (wr_strobe)
      begin
         if (dp_index == `EPIU_IDX_GROUP_ENABLE)
         begin
            group_enable <= hwdata[2:0];
         end
         if (dp_index == `EPIU_IDX_MASK_HIGH)
         begin
            pin_mask[2] <= hwdata[7:0];
         end
         if (dp_index == `EPIU_IDX_MASK_MID)
         begin
            pin_mask[1] <= hwdata[7:0] & `EPIU_MASK_MID_BITS;
         end
         if (dp_index == `EPIU_IDX_MASK_LOW)
         begin
            pin_mask[0] <= hwdata[7:0];
         end
      end
   end

endmodule // epiu_top

// ---- verification/epiu_top_monitor.sv ----
/*
   Checker for the external pin interrupt unit, bound to its top module.
   Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ns
module epiu_top_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire epiu_pkg::epiu_pins_type pad_in,
   input wire logic global_irq_enable,
   input wire epiu_pkg::epiu_req_type handler_entry,
   input wire epiu_pkg::epiu_req_type irq_request,
   input wire logic wake_request
);
   epiu_pkg::epiu_pins_type pad_q;
   logic [3:0] quiet;
   logic [9:0] rd_idx;
   logic rd_pend;
   logic rd_out;
   wire taken = hsel && hready && htrans[1] && hsize == 3'h2;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ==========================================================
   // Helper logic
   // Counts quiet cycles on the pads so that no set event is still in flight.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pad_q <= 26'h3FFFFFF;
         quiet <= 4'h0;
      end
      else
      begin
         pad_q <= pad_in;
         if (pad_in != pad_q)
            quiet <= 4'h0;
         else if (quiet != 4'hF)
            quiet <= quiet + 4'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_pend <= 1'b0;
         rd_out <= 1'b0;
         rd_idx <= 10'h000;
      end
      else
      begin
         rd_pend <= taken && !hwrite;
         rd_out <= rd_pend;
         if (taken)
            rd_idx <= haddr[11:2];
      end
   end

   // ==========================================================
   // Assertions
   AST_GLOBAL_GATE: assert property (!global_irq_enable |-> irq_request == 5'h00)
      else $error("request while global bit clear");
   AST_WRITE_ANSWER: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   AST_READ_ANSWER: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer timing wrong");
   AST_SENSE_RSVD: assert property (rd_out && rd_idx == 10'h070 |-> hrdata[31:4] == 28'h0)
      else $error("sense unused bits not zero");
   AST_EXT_RSVD: assert property (rd_out && (rd_idx == 10'h01D || rd_idx == 10'h071)
      |-> hrdata[31:2] == 30'h0)
      else $error("enable or flag unused bits not zero");
   AST_GROUP_RSVD: assert property (rd_out && (rd_idx == 10'h068 || rd_idx == 10'h072)
      |-> hrdata[31:3] == 29'h0)
      else $error("group register unused bits not zero");
   AST_MID_RSVD: assert property (rd_out && rd_idx == 10'h06C |-> hrdata[31:7] == 25'h0)
      else $error("middle mask top bits not zero");
   AST_GROUP_CLEAR: assert property (handler_entry.group[0] && quiet >= 4'h6
      |=> !irq_request.group[0])
      else $error("group request kept after handler entry");
   AST_PIN_CLEAR: assert property (handler_entry.pin[1] && pad_in.irq[1] && quiet >= 4'h6
      |=> !irq_request.pin[1])
      else $error("pin request kept after handler entry");
endmodule // epiu_top_monitor

bind epiu_top epiu_top_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .pad_in(pad_in), .global_irq_enable(global_irq_enable),
   .handler_entry(handler_entry), .irq_request(irq_request), .wake_request(wake_request));

// ---- verification/epiu_pad_model.sv ----
/*
   Model of the sources on the dedicated and pin-change pads.
   Assumes the bench sets the wanted levels just after a rising edge.
*/
`timescale 1ns/1ns
module epiu_pad_model (
   input wire logic hclk,
   input wire logic [25:0] want,
   output epiu_pkg::epiu_pins_type pads
);
   initial pads = 26'h3FFFFFF;

   // A level stays until the bench asks for another, so a low level outlasts any wait.
   always @(posedge hclk)
   begin
      pads <= want;
   end
endmodule // epiu_pad_model

// ---- verification/tb_top.sv ----
/*
   Self-checking bench for the external pin interrupt unit.
   Assumes the checker is bound to the top module by its own file.
*/
`timescale 1ns/1ns
`include "epiu_defs.svh"
module tb_top;
   localparam logic [9:0] sense_idx = `EPIU_IDX_SENSE;
   localparam logic [9:0] flag_idx = `EPIU_IDX_EXT_FLAGS;
   localparam logic [9:0] gflag_idx = `EPIU_IDX_GROUP_FLAGS;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, gie, hreadyout, hresp, wake;
   logic [31:0] haddr, hwdata, hrdata, q, e;
   logic rsp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [25:0] want;
   epiu_pkg::epiu_pins_type pads;
   epiu_pkg::epiu_req_type hent, req;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [9:0] idx [8] = '{10'h01D, 10'h068, 10'h06D, 10'h06C, 10'h06B, 10'h070, 10'h071, 10'h072};
   logic [31:0] msk [8] = '{32'h3, 32'h7, 32'hFF, 32'h7F, 32'hFF, 32'hF, 32'h0, 32'h0};

   always #5 hclk = ~hclk;

   epiu_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pad_in(pads), .global_irq_enable(gie),
      .handler_entry(hent), .irq_request(req), .wake_request(wake));
   epiu_pad_model pm (.hclk(hclk), .want(want), .pads(pads));

   // ==========================================================
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Ready, read data and response are taken at the rising edge, as the slave's flops see them.
   task xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, i, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      rsp = hresp;
   endtask

   task wr(input logic [9:0] i, input logic [31:0] d);
      xfer(1'b1, i, d);
   endtask

   task rd(input logic [9:0] i, input logic [31:0] x);
      xfer(1'b0, i, 32'h0);
      chk(q, x);
      chk({31'h0, rsp}, {31'h0, `EPIU_HRESP_OKAY});
   endtask

   task settle;
      repeat (8) @(posedge hclk);
      @(negedge hclk);
   endtask

   task pulse(input epiu_pkg::epiu_req_type v);
      @(posedge hclk);
      hent <= v;
      @(posedge hclk);
      hent <= 5'h00;
   endtask

   task wrap_up;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         wrap_up();
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = `EPIU_HSIZE_WORD;
      hwdata = 32'h0;
      gie = 1'b0;
      hent = 5'h00;
      want = `EPIU_PIN_IDLE;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         rd(idx[k], 32'h0);
         wr(idx[k], 32'hFFFFFFFF);
         rd(idx[k], msk[k]);
      end
      wr(10'h3FF, 32'hFFFFFFFF);
      rd(10'h3FF, 32'h0);
      @(posedge hclk) gie <= 1'b1;
      for (int g = 0; g < 3; g++)
      begin
         @(posedge hclk) want[g * 8 + 3] <= 1'b0;
         repeat (2) @(negedge hclk);
         chk({31'h0, wake}, 32'h1);
         settle();
         chk({27'h0, req}, 32'h1 << g);
         chk({31'h0, wake}, 32'h0);
         rd(gflag_idx, 32'h1 << g);
         pulse(5'(1 << g));
         rd(gflag_idx, 32'h0);
      end
      wr(`EPIU_IDX_MASK_LOW, 32'h0);
      @(posedge hclk) want[15] <= 1'b0;
      want[0] <= 1'b0;
      settle();
      rd(gflag_idx, 32'h0);
      @(posedge hclk) want[16] <= 1'b0;
      settle();
      wr(gflag_idx, 32'h3);
      rd(gflag_idx, 32'h4);
      wr(gflag_idx, 32'h4);
      rd(gflag_idx, 32'h0);
      for (int p = 0; p < 2; p++)
      begin
         for (int m = 1; m < 4; m++)
         begin
            wr(sense_idx, 32'(m) << (2 * p));
            wr(flag_idx, 32'h3);
            @(posedge hclk) want[24 + p] <= 1'b0;
            settle();
            e = (m != 3) ? (32'h1 << p) : 32'h0;
            chk({27'h0, req}, e << 3);
            wr(flag_idx, 32'h0);
            rd(flag_idx, e);
            wr(flag_idx, e);
            rd(flag_idx, 32'h0);
            @(posedge hclk) want[24 + p] <= 1'b1;
            settle();
            e = (m != 2) ? (32'h1 << p) : 32'h0;
            rd(flag_idx, e);
            pulse(5'(e << 3));
            rd(flag_idx, 32'h0);
         end
      end
      wr(sense_idx, 32'h0);
      @(posedge hclk) want[25] <= 1'b0;
      settle();
      chk({27'h0, req}, 32'h10);
      chk({31'h0, wake}, 32'h1);
      rd(flag_idx, 32'h0);
      @(posedge hclk) gie <= 1'b0;
      @(negedge hclk);
      chk({27'h0, req}, 32'h0);
      wrap_up();
   end
endmodule // tb_top
